// File: core/lps_pkg.sv
// holds the register map, reset values, timing figures and state types of the
// light/proximity result slice; assumes a 100 MHz system clock
package lps_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] REG_AMB_HI   = 8'h85;
  localparam logic [7:0] REG_AMB_LO   = 8'h86;
  localparam logic [7:0] REG_PROX_HI  = 8'h87;
  localparam logic [7:0] REG_PROX_LO  = 8'h88;
  localparam logic [7:0] REG_FREQ_SEL = 8'h89;
  localparam int         FREQ_LSB     = 0;
  localparam int         FREQ_MSB     = 1;
  localparam logic [1:0] FREQ_RST     = 2'h2;
  localparam logic [15:0] RESULT_RST  = 16'h0000;
  localparam logic [7:0] PTR_RST      = 8'h00;

  // ************************************************************
  // timing: fastest ir test frequency, others are halvings of it
  // ************************************************************
  localparam int CLK_HZ       = 100_000_000;
  localparam int IR_BASE_HZ   = 3_125_000;
  localparam int IR_HALF_BASE = CLK_HZ / (2 * IR_BASE_HZ);
  localparam int BIT_LAST     = 7;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_ACK   = 9'h004,
    ST_REG   = 9'h008,
    ST_WDATA = 9'h010,
    ST_RDATA = 9'h020,
    ST_MACK  = 9'h040,
    ST_NACK  = 9'h080,
    ST_SKIP  = 9'h100
  } lps_state_t;

  typedef struct packed {
    logic [15:0] value;
    logic        valid;
  } lps_result_t;

  typedef struct packed {
    lps_state_t  state;
    logic        scl_prev;
    logic        sda_prev;
    logic [2:0]  bit_cnt;
    logic        byte_done;
    logic [7:0]  rx;
    logic [7:0]  tx;
    logic [7:0]  ptr;
    logic        is_read;
    logic        got_reg;
    logic        sda_oe;
    logic [1:0]  freq;
    logic [15:0] amb;
    logic [15:0] prox;
    logic [6:0]  div;
    logic        ir;
  } lps_regs_t;

endpackage

// File: core/lps_top.sv
// i2c target holding the ambient and proximity results and the ir test
// frequency select, plus the ir square-wave generator
// assumes scl and sda arrive already synchronous to CLOCK
//
// What this block does
// - ambient result 16 bits: high byte at 85h, low byte at 86h
// - ambient bytes are read-only; writes never change them
// - proximity result 16 bits: high byte at 87h, low byte at 88h
// - proximity bytes are read-only, low byte bits 7:0, high 15:8
// - 89h bits 1:0 select ir frequency 3.125M/1.5625M/781.25k/390.625k
// - frequency select resets to code 2, 781.25 kHz
// - square ir stimulus at the selected frequency during proximity measurement
// - pointer advances by one after each read byte
`timescale 1ns/1ps
module lps_top
  import lps_pkg::*;
#(
  parameter logic [6:0] I2C_ADDR = 7'h13  // arbitrary value
) (
  // clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RST,
  // i2c pins, sda open drain
  input  wire logic              SCL,
  input  wire logic              SDA_IN,
  output      logic              SDA_OUT,
  output      logic              SDA_OE,
  // results from the measurement engines
  input  wire lps_pkg::lps_result_t AMB,
  input  wire lps_pkg::lps_result_t PROX,
  // proximity measurement and ir stimulus
  input  wire logic              PROX_MEAS,
  output      logic              IR_DRIVE,
  output      logic [1:0]        FREQ_SEL
);
  import lps_pkg::*;

  if (IR_HALF_BASE < 1 || IR_HALF_BASE * 8 > 128) begin : g_bad_clock
    $error("clock rate cannot serve the ir divider");
  end

  lps_regs_t st_ff;
  lps_regs_t nxt_st;
  logic      scl_rise;
  logic      scl_fall;
  logic      start_cond;
  logic      stop_cond;
  logic      rd_load;
  logic      wr_strobe;
  logic [6:0] half_last;

  // ************************************************************
  // read mux
  // ************************************************************
  function automatic logic [7:0] read_byte(input lps_regs_t s);
    logic [7:0] r;
    r = 8'h00;
    unique case (s.ptr)
      REG_AMB_HI:   r = s.amb[15:8];
      REG_AMB_LO:   r = s.amb[7:0];
      REG_PROX_HI:  r = s.prox[15:8];
      REG_PROX_LO:  r = s.prox[7:0];
      REG_FREQ_SEL: r = {6'h00, s.freq};
      default:      r = 8'h00;
    endcase
    return r;
  endfunction

  assign scl_rise   = SCL & ~st_ff.scl_prev;
  assign scl_fall   = ~SCL & st_ff.scl_prev;
  assign start_cond = SCL & st_ff.scl_prev & st_ff.sda_prev & ~SDA_IN;
  assign stop_cond  = SCL & st_ff.scl_prev & ~st_ff.sda_prev & SDA_IN;
  // last count of a half period; the slowest code ends on 127, so 7 bits suffice
  assign half_last  = 7'((IR_HALF_BASE << st_ff.freq) - 1);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    nxt_st          = st_ff;
    rd_load         = 1'b0;
    wr_strobe       = 1'b0;
    nxt_st.scl_prev = SCL;
    nxt_st.sda_prev = SDA_IN;

    // results only change from their engines, never from the bus
    if (AMB.valid) begin
      nxt_st.amb = AMB.value;
    end
    if (PROX.valid) begin
      nxt_st.prox = PROX.value;
    end

    // byte receive shared by address, register and data phases
    if (scl_rise && (st_ff.state inside {ST_ADDR, ST_REG, ST_WDATA})) begin
      nxt_st.rx        = {st_ff.rx[6:0], SDA_IN};
      nxt_st.bit_cnt   = st_ff.bit_cnt + 3'h1;
      nxt_st.byte_done = (st_ff.bit_cnt == 3'(BIT_LAST));
    end

    unique case (st_ff.state)
      ST_IDLE, ST_SKIP: begin
        nxt_st.sda_oe = 1'b0;
      end
      ST_ADDR: begin
        if (scl_fall && st_ff.byte_done) begin
          nxt_st.byte_done = 1'b0;
          if (st_ff.rx[7:1] == I2C_ADDR) begin
            nxt_st.is_read = st_ff.rx[0];
            nxt_st.sda_oe  = 1'b1;
            nxt_st.state   = ST_ACK;
          end else begin
            nxt_st.state = ST_SKIP;
          end
        end
      end
      ST_REG, ST_WDATA: begin
        if (scl_fall && st_ff.byte_done) begin
          nxt_st.byte_done = 1'b0;
          nxt_st.sda_oe    = 1'b1;
          nxt_st.state     = ST_ACK;
          if (st_ff.state == ST_REG) begin
            nxt_st.ptr     = st_ff.rx;
            nxt_st.got_reg = 1'b1;
          end else begin
            wr_strobe  = 1'b1;
            nxt_st.ptr = st_ff.ptr + 8'h01;
            if (st_ff.ptr == REG_FREQ_SEL) begin
              nxt_st.freq = st_ff.rx[FREQ_MSB:FREQ_LSB];
            end
          end
        end
      end
      ST_ACK: begin
        if (scl_fall) begin
          nxt_st.bit_cnt = 3'h0;
          if (st_ff.is_read) begin
            rd_load       = 1'b1;
          end else begin
            nxt_st.sda_oe = 1'b0;
            nxt_st.state  = st_ff.got_reg ? ST_WDATA : ST_REG;
          end
        end
      end
      ST_RDATA: begin
        if (scl_fall) begin
          if (st_ff.bit_cnt == 3'(BIT_LAST)) begin
            nxt_st.sda_oe = 1'b0;
            nxt_st.state  = ST_MACK;
          end else begin
            nxt_st.tx      = {st_ff.tx[6:0], 1'b0};
            nxt_st.sda_oe  = ~st_ff.tx[6];
            nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
          end
        end
      end
      ST_MACK: begin
        // a host nack ends the read; it then sends stop or start
        if (scl_rise) begin
          nxt_st.state = SDA_IN ? ST_NACK : ST_ACK;
        end
      end
      ST_NACK: begin
        nxt_st.sda_oe = 1'b0;
      end
      default: begin
        nxt_st.state  = ST_IDLE;
        nxt_st.sda_oe = 1'b0;
      end
    endcase

    // mack reuses ack to reload the next byte on the coming fall
    if (st_ff.state == ST_MACK && scl_rise && !SDA_IN) begin
      nxt_st.is_read = 1'b1;
    end
    if (rd_load) begin
      nxt_st.tx      = read_byte(st_ff);
      nxt_st.sda_oe  = ~nxt_st.tx[7];
      nxt_st.ptr     = st_ff.ptr + 8'h01;
      nxt_st.bit_cnt = 3'h0;
      nxt_st.state   = ST_RDATA;
    end

    if (start_cond) begin
      nxt_st.state     = ST_ADDR;
      nxt_st.bit_cnt   = 3'h0;
      nxt_st.byte_done = 1'b0;
      nxt_st.got_reg   = 1'b0;
      nxt_st.sda_oe    = 1'b0;
    end else if (stop_cond) begin
      nxt_st.state  = ST_IDLE;
      nxt_st.sda_oe = 1'b0;
    end

    // ir square wave, halted and low outside a proximity measurement
    if (!PROX_MEAS) begin
      nxt_st.div = 7'h00;
      nxt_st.ir  = 1'b0;
    end else if (st_ff.div >= half_last) begin
      nxt_st.div = 7'h00;
      nxt_st.ir  = ~st_ff.ir;
    end else begin
      nxt_st.div = st_ff.div + 7'h01;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st_ff          <= '0;
      st_ff.state    <= ST_IDLE;
      st_ff.scl_prev <= 1'b1;
      st_ff.sda_prev <= 1'b1;
      st_ff.ptr      <= PTR_RST;
      st_ff.freq     <= FREQ_RST;
      st_ff.amb      <= RESULT_RST;
      st_ff.prox     <= RESULT_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign SDA_OUT  = 1'b0;
  assign SDA_OE   = st_ff.sda_oe;
  assign IR_DRIVE = st_ff.ir;
  assign FREQ_SEL = st_ff.freq;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_load(logic [7:0] a);
    rd_load && st_ff.ptr == a;
  endsequence

  a_freq_after_reset: assert property ($fell(RST) |-> st_ff.freq == 2'h2)
    else $error("frequency select not at 781.25 kHz code after reset");
  a_amb_high_read: assert property (s_load(REG_AMB_HI) |=> st_ff.tx == $past(st_ff.amb[15:8]))
    else $error("ambient high byte not loaded for read");
  a_amb_readonly: assert property (wr_strobe && !AMB.valid |=> $stable(st_ff.amb))
    else $error("bus write changed ambient result");
  a_prox_high_read: assert property (s_load(REG_PROX_HI) |=> st_ff.tx == $past(st_ff.prox[15:8]))
    else $error("proximity high byte not loaded for read");
  a_prox_low_read: assert property (s_load(REG_PROX_LO) |=> st_ff.tx == $past(st_ff.prox[7:0]))
    else $error("proximity low byte not loaded for read");
  a_freq_write: assert property (wr_strobe && st_ff.ptr == REG_FREQ_SEL |=> st_ff.freq == $past(st_ff.rx[1:0]))
    else $error("frequency select write lost");
  a_ir_half_period: assert property ($rose(st_ff.ir) && st_ff.freq == 2'h0 && PROX_MEAS |-> ##16 (!st_ff.ir || !PROX_MEAS || st_ff.freq != 2'h0))
    else $error("ir half period wrong at fastest setting");
  a_ptr_advance: assert property (rd_load |=> st_ff.ptr == $past(st_ff.ptr) + 8'h01)
    else $error("pointer did not advance after read");
  a_freq_upper_zero: assert property (s_load(REG_FREQ_SEL) |=> st_ff.tx[7:2] == 6'h00)
    else $error("unused frequency register bits not zero");

endmodule

// File: test/lps_i2c_host.sv
// bus host model: drives scl and pulls sda low, one bit every twelve clocks
// assumes the bench resolves the sda wire with a pull-up and feeds it back
`timescale 1ns/1ps
module lps_i2c_host (
  input  wire logic clk,
  input  wire logic sda,
  output      logic scl,
  output      logic sda_low
);
  // ************************************************************
  // bit level
  // ************************************************************
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // each phase is four clocks, above the three the target needs
  task automatic hold();
    repeat (4) @(posedge clk);
    #1;
  endtask

  // also serves as repeated start between address write and read
  task automatic start();
    sda_low = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b1;
    hold();
    scl = 1'b0;
    hold();
  endtask

  task automatic stop();
    sda_low = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b0;
    hold();
  endtask

  task automatic xbit(input logic b, output logic r);
    sda_low = ~b;
    hold();
    scl = 1'b1;
    hold();
    r = sda;
    scl = 1'b0;
    hold();
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(d[i], r);
    xbit(1'b1, r);
    ack = ~r;
  endtask

  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
    xbit(last, r);
  endtask
endmodule

// File: test/testbench.sv
// self-checking bench of the result and frequency registers and ir stimulus
// assumes lps_pkg and lps_top compiled first, host model beside it
`timescale 1ns/1ps
module testbench;
  import lps_pkg::*;
  localparam logic [6:0] DEV = 7'h13;  // arbitrary value
  logic        clock, rst, prox_meas, sda_oe, sda_out, ir_drive, scl, sda_low;
  logic [1:0]  freq_sel;
  lps_result_t amb, prox;
  int          err_count, tests_run;
  wire         sda = ~(sda_low | sda_oe);
  // address in the high byte, expected read in the low byte
  logic [15:0] rows [6] = '{16'h85a5, 16'h865a, 16'h873c, 16'h88c3, 16'h8902, 16'h8a00};

  lps_top #(.I2C_ADDR(DEV)) dut (.CLOCK(clock), .RST(rst), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .AMB(amb), .PROX(prox), .PROX_MEAS(prox_meas),
    .IR_DRIVE(ir_drive), .FREQ_SEL(freq_sel));
  lps_i2c_host host (.clk(clock), .sda(sda), .scl(scl), .sda_low(sda_low));

  // ************************************************************
  // checks and transfers
  // ************************************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      err_count++;
      $display("[FAIL] %0t period %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input int n, output logic [15:0] v);
    logic k;
    v = '0;
    host.start();
    host.wbyte({DEV, 1'b0}, k);
    chk1(k, 1'b1);
    host.wbyte(a, k);
    chk1(k, 1'b1);
    // odd registers close the addressing write with a stop, the rest with a repeated start
    if (a[0]) host.stop();
    host.start();
    host.wbyte({DEV, 1'b1}, k);
    chk1(k, 1'b1);
    for (int i = 0; i < n; i++) host.rbyte(i == n - 1, v[15 - 8 * i -: 8]);
    host.stop();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic k;
    host.start();
    host.wbyte({DEV, 1'b0}, k);
    host.wbyte(a, k);
    host.wbyte(d, k);
    host.stop();
  endtask

  // cycles between the first two rising edges of the ir output
  task automatic ir_period(output int p);
    int   t0;
    logic q;
    t0 = -1;
    p = 0;
    q = ir_drive;
    for (int n = 0; n < 1200 && p == 0; n++) begin
      @(posedge clock);
      #1;
      if (ir_drive === 1'b1 && q === 1'b0) begin
        if (t0 < 0) t0 = n;
        else p = n - t0;
      end
      q = ir_drive;
    end
  endtask

  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    repeat (50000) @(posedge clock);
    err_count++;
    test_done();
  end

  initial begin
    logic [15:0] v;
    int          p;
    rst = 1'b1;
    prox_meas = 1'b0;
    amb = '0;
    prox = '0;
    err_count = 0;
    tests_run = 0;
    repeat (8) @(posedge clock);
    #1 rst = 1'b0;
    chk8({6'h00, freq_sel}, 8'h02);
    repeat (2) @(posedge clock);
    #1;
    amb = '{16'ha55a, 1'b1};
    prox = '{16'h3cc3, 1'b1};
    @(posedge clock);
    #1;
    amb.valid = 1'b0;
    prox.valid = 1'b0;
    foreach (rows[i]) begin
      rd(rows[i][15:8], 1, v);
      chk8(v[15:8], rows[i][7:0]);
    end
    rd(REG_PROX_HI, 2, v);
    chk8(v[7:0], 8'hc3);
    wr(REG_AMB_HI, 8'h00);
    rd(REG_AMB_HI, 2, v);
    chk8(v[15:8], 8'ha5);
    chk8(v[7:0], 8'h5a);
    wr(REG_FREQ_SEL, 8'hff);
    rd(REG_FREQ_SEL, 1, v);
    chk8(v[15:8], 8'h03);
    for (int c = 0; c < 4; c++) begin
      wr(REG_FREQ_SEL, 8'(c));
      chk8({6'h00, freq_sel}, 8'(c));
      prox_meas = 1'b1;
      ir_period(p);
      chk_n(p, 32 << c);
      prox_meas = 1'b0;
      repeat (2) @(posedge clock);
      #1;
      chk1(ir_drive, 1'b0);
    end
    // reset in mid-run while the ir output toggles: everything returns to reset values
    wr(REG_FREQ_SEL, 8'h01);
    prox_meas = 1'b1;
    repeat (40) @(posedge clock);
    #1 rst = 1'b1;
    @(posedge clock);
    #1;
    chk1(ir_drive, 1'b0);
    chk8({6'h00, freq_sel}, 8'h02);
    prox_meas = 1'b0;
    repeat (7) @(posedge clock);
    #1 rst = 1'b0;
    chk1(sda_out, 1'b0);
    repeat (2) @(posedge clock);
    #1;
    rd(REG_FREQ_SEL, 2, v);
    chk8(v[15:8], 8'h02);
    chk8(v[7:0], 8'h00);
    test_done();
  end
endmodule
